// file: logic/ram_block_params.svh
/*
  Offsets, field positions, reset values and sizes of the 32x4 RAM block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef RAM_BLOCK_PARAMS_SVH
`define RAM_BLOCK_PARAMS_SVH

// ----------------------------------------
// register byte offsets (low 8 address bits)
// ----------------------------------------
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_CLEAR      8'h08
`define MEM_WIN_BIT    7
`define MEM_IDX_LSB    2

// ----------------------------------------
// control fields and reset value
// ----------------------------------------
`define CTRL_DUAL_BIT  0
`define CTRL_SYNC_BIT  1
`define CTRL_ODL_BIT   2
`define CTRL_RESET     3'h7

// ----------------------------------------
// status fields
// ----------------------------------------
`define ST_DUAL_BIT    0
`define ST_SYNC_BIT    1
`define ST_SCLK_BIT    2
`define ST_ADDR_LSB    4
`define ST_WEN_BIT     12
`define ST_DATA_LSB    16

// ----------------------------------------
// array size
// ----------------------------------------
`define RAM_WORDS      32
`define RAM_AW         5
`define RAM_DW         4

`endif

// file: logic/ram_block_pkg.sv
/*
  Types shared by the RAM block: control word, front-end latch contents,
  bus states. Assumes the params header for the sizes.
*/
`include "ram_block_params.svh"

package ram_block_pkg;

  // control register, bit 0 is dual_port
  typedef struct packed {
    logic output_drive_low;
    logic sync_write;
    logic dual_port;
  } ctrl_t;

  // write-side front-end latch contents
  typedef struct packed {
    logic [`RAM_AW-1:0] addr;
    logic               we_n;
    logic [`RAM_DW-1:0] data;
  } front_t;

  // bus slave states
  typedef enum logic {
    bus_idle,
    bus_read
  } bus_state_t;

endpackage

// file: logic/ram_block.sv
/*
  32x4 distributed RAM block with an AHB-Lite register slave for mode
  control, status, clear and a read-only view of the array.
  Assumes: everything synchronous to hclk, sector_clk sampled as a level,
  single whole-word AHB transfers, the one slave on its bus.
*/
// What this block does
// - Holds a storage array of 32 words of 4 bits each.
// - Runs single-ported or dual-ported, with synchronous or asynchronous writes.
// - Takes write data on a 4-bit input bus and gives read data on a separate 4-bit bus.
// - Takes a 5-bit write address and a separate 5-bit read address.
// - Single-ported, the write address is the shared address and the data port is two-way.
// - A right-most block ignores its read address and runs single-ported only.
// - Reads and writes proceed independently; the read side needs no write clock.
// - A front-end latch passes its input while its load is 1 and holds while it is 0.
// - The front-end latches catch write address, active-low write enable and write data.
// - Each stored nibble is a latch that with the front latch acts as an edge store.
// - A nibble follows write data only when addressed, load is 1 and enable is 0.
// - Except during a clear, a nibble holds when not addressed, when load is 0 or when enable is 1.
// - Both load selectors switch together: sector clock when synchronous (inverted for the front latch), 1 otherwise.
// - Synchronous writes use the sector clock of the neighbouring sector column.
// - Writing any value to the clear location clears the whole array.
`timescale 1ns/1ps
`include "ram_block_params.svh"

module ram_block #(
  parameter bit RIGHT_MOST = 1'b0
) (
  // clock, reset, enable
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 ce,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // sector column clock, sampled
  input  wire logic                 sector_clk,
  // write side
  input  wire logic [`RAM_AW-1:0]   wr_addr,
  input  wire logic                 wr_enable_n,
  input  wire logic [`RAM_DW-1:0]   din_in,
  output logic      [`RAM_DW-1:0]   din_out,
  output logic                      din_oe,
  // read side
  input  wire logic [`RAM_AW-1:0]   rd_addr,
  output logic      [`RAM_DW-1:0]   rd_data,
  output logic                      rd_data_oe
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  ram_block_pkg::bus_state_t state;
  ram_block_pkg::bus_state_t next_state;
  logic [7:0]                addr_q;
  logic [7:0]                next_addr_q;
  logic                      wr_q;
  logic                      next_wr_q;
  logic                      next_hreadyout;
  logic [31:0]               next_hrdata;
  logic [31:0]               status;
  logic [31:0]               bus_word;
  ram_block_pkg::ctrl_t      ctrl;
  ram_block_pkg::ctrl_t      next_ctrl;
  ram_block_pkg::front_t     front;
  ram_block_pkg::front_t     next_front;
  logic                      clear;
  logic                      dual_eff;
  logic                      front_load;
  logic                      mem_load;
  logic [`RAM_AW-1:0]        rd_sel;
  logic [`RAM_DW-1:0]        mem      [`RAM_WORDS];
  logic [`RAM_DW-1:0]        next_mem [`RAM_WORDS];
  logic [`RAM_DW-1:0]        next_din_out;
  logic                      next_din_oe;
  logic [`RAM_DW-1:0]        next_rd_data;
  logic                      next_rd_data_oe;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------

  // right-most blocks never run dual-ported
  assign dual_eff = ctrl.dual_port & ~RIGHT_MOST;

  // both load selectors follow one mode bit
  // front opens while the sector clock is low, the array while high: a rising-edge store
  assign front_load = ctrl.sync_write ? ~sector_clk : 1'b1;
  assign mem_load   = ctrl.sync_write ? sector_clk : 1'b1;

  // shared address when single-ported
  assign rd_sel = dual_eff ? rd_addr : wr_addr;

  // clear strobe from the bus data phase
  assign clear = wr_q && (addr_q == `OFS_CLEAR);

  // status word
  always_comb begin
    status = 32'h0000_0000;
    status[`ST_DUAL_BIT] = dual_eff;
    status[`ST_SYNC_BIT] = ctrl.sync_write;
    status[`ST_SCLK_BIT] = sector_clk;
    status[`ST_ADDR_LSB +: `RAM_AW] = front.addr;
    status[`ST_WEN_BIT] = front.we_n;
    status[`ST_DATA_LSB +: `RAM_DW] = front.data;
  end

  // word returned for the latched offset; unmapped offsets read 0
  always_comb begin
    bus_word = 32'h0000_0000;
    if (addr_q[`MEM_WIN_BIT]) begin
      bus_word[`RAM_DW-1:0] = mem[addr_q[`MEM_IDX_LSB +: `RAM_AW]];
    end else if (addr_q == `OFS_CTRL) begin
      bus_word[2:0] = ctrl;
    end else if (addr_q == `OFS_STATUS) begin
      bus_word = status;
    end
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------

  // writes end with no wait, reads take one wait state
  always_comb begin
    next_state     = state;
    next_addr_q    = addr_q;
    next_wr_q      = 1'b0;
    next_hreadyout = 1'b1;
    next_hrdata    = hrdata;
    case (state)
      ram_block_pkg::bus_idle: begin
        if (hsel && htrans[1] && hready) begin
          next_addr_q = haddr[7:0];
          next_wr_q   = hwrite;
          if (!hwrite) begin
            next_state     = ram_block_pkg::bus_read;
            next_hreadyout = 1'b0;
          end
        end
      end
      ram_block_pkg::bus_read: begin
        next_state  = ram_block_pkg::bus_idle;
        next_hrdata = bus_word;
      end
      default: begin
        next_state = ram_block_pkg::bus_idle;
      end
    endcase
  end

  // bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ram_block_pkg::bus_idle;
      addr_q    <= 8'h00;
      wr_q      <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else if (ce) begin
      state     <= next_state;
      addr_q    <= next_addr_q;
      wr_q      <= next_wr_q;
      hreadyout <= next_hreadyout;
      hrdata    <= next_hrdata;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------

  // mode bits from software
  always_comb begin
    next_ctrl = ctrl;
    if (wr_q && (addr_q == `OFS_CTRL)) begin
      next_ctrl = hwdata[2:0];
    end
  end

  // control flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `CTRL_RESET;
    end else if (ce) begin
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------
  // front-end latches
  // ----------------------------------------

  // pass while load is 1, hold while 0
  always_comb begin
    next_front = front;
    if (front_load) begin
      next_front.addr = wr_addr;
      next_front.we_n = wr_enable_n;
      next_front.data = din_in;
    end
  end

  // front latch flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      front <= '{addr: '0, we_n: 1'b1, data: '0};
    end else if (ce) begin
      front <= next_front;
    end
  end

  // ----------------------------------------
  // storage array
  // ----------------------------------------

  // one nibble per entry, memory latch after the front latch
  for (genvar i = 0; i < `RAM_WORDS; i++) begin : g_word
    always_comb begin
      next_mem[i] = mem[i];
      if (clear) begin
        next_mem[i] = '0;
      end else if (mem_load && !front.we_n && (front.addr == `RAM_AW'(i))) begin
        next_mem[i] = front.data;
      end
      // otherwise the nibble holds
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        mem[i] <= '0;
      end else if (ce) begin
        mem[i] <= next_mem[i];
      end
    end
  end

  // ----------------------------------------
  // read outputs
  // ----------------------------------------

  // dual-ported read port; needs no write clock, only the address
  always_comb begin
    next_rd_data    = '0;
    next_rd_data_oe = 1'b0;
    if (!ctrl.output_drive_low && dual_eff) begin
      next_rd_data    = mem[rd_sel];
      next_rd_data_oe = 1'b1;
    end
  end

  // read port flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data    <= '0;
      rd_data_oe <= 1'b0;
    end else if (ce) begin
      rd_data    <= next_rd_data;
      rd_data_oe <= next_rd_data_oe;
    end
  end

  // single-ported: shared pin driven only while not writing
  // the pin is let go one cycle after write enable falls
  always_comb begin
    next_din_out = '0;
    next_din_oe  = 1'b0;
    if (!ctrl.output_drive_low && !dual_eff && wr_enable_n) begin
      next_din_out = mem[rd_sel];
      next_din_oe  = 1'b1;
    end
  end

  // data pin flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din_out <= '0;
      din_oe  <= 1'b0;
    end else if (ce) begin
      din_out <= next_din_out;
      din_oe  <= next_din_oe;
    end
  end

  // ----------------------------------------
  // unused inputs
  // ----------------------------------------

  // hsize is accepted but every access is a whole word
  logic unused_hsize;
  assign unused_hsize = ^hsize;

endmodule

// file: tb/array_user.sv
/*
  user logic in the array: writes one nibble on request, makes the sector clock, resolves the two-way data pin.
  assumes requests arrive just after a rising hclk edge.
*/
`timescale 1ns/1ps
module array_user (
  // requests from the bench
  input  wire logic       hclk,
  input  wire logic       go,
  input  wire logic       sync,
  input  wire logic [4:0] addr,
  input  wire logic [3:0] data,
  // block side
  input  wire logic       din_oe,
  input  wire logic [3:0] din_out,
  output logic      [4:0] wr_addr = 5'h0,
  output logic            wr_enable_n,
  output logic      [3:0] din_in,
  output logic            sector_clk = 1'b0
);
  logic [2:0] cnt = 3'h0;
  logic [3:0] val = 4'h0;
  // write held four cycles; sector clock stands still unless sync
  always @(posedge hclk) begin
    sector_clk <= sync ? ~sector_clk : 1'b0;
    cnt <= go ? 3'h4 : cnt - 3'(cnt != 3'h0);
    if (go) wr_addr <= addr;
    if (go) val <= data;
  end
  assign wr_enable_n = cnt == 3'h0;
  // released pin shows the last nibble while writing, its inverse otherwise
  assign din_in = din_oe ? din_out : (wr_enable_n ? ~val : val);
endmodule

// file: tb/ram_block_chk.sv
/*
  checker for the ram block bus answers and user-side outputs.
  assumes one hclk domain and binding to ram_block.
*/
`timescale 1ns/1ps
module ram_block_chk (
  // clock, reset, enable
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // user side
  input wire logic        wr_enable_n,
  input wire logic        din_oe,
  input wire logic [3:0]  rd_data,
  input wire logic        rd_data_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // requests taken by the slave
  sequence s_req; ce && hsel && htrans[1] && hready && hreadyout; endsequence
  sequence s_rd; s_req ##0 !hwrite; endsequence
  sequence s_wr; s_req ##0 hwrite; endsequence
  property p_okay; !hresp; endproperty
  property p_rd_wait; s_rd |=> !hreadyout; endproperty
  property p_wr_nowait; s_wr |=> hreadyout; endproperty
  property p_wait_once; !hreadyout && ce |=> hreadyout; endproperty
  property p_hold_rdata; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
  property p_float; !rd_data_oe |-> rd_data == 4'h0; endproperty
  property p_din_off; (!wr_enable_n && ce)[*2] |=> !din_oe; endproperty
  property p_freeze; !ce |=> $stable({hrdata, hreadyout, rd_data, rd_data_oe, din_oe}); endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  a_rd_wait: assert property (p_rd_wait) else $error("read without wait state");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_wait_once: assert property (p_wait_once) else $error("wait state too long");
  a_hold_rdata: assert property (p_hold_rdata) else $error("read data moved");
  a_float: assert property (p_float) else $error("read data while off");
  a_din_off: assert property (p_din_off) else $error("data pin driven in write");
  a_freeze: assert property (p_freeze) else $error("outputs moved with ce low");
endmodule
bind ram_block ram_block_chk u_ram_block_chk (.hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .wr_enable_n, .din_oe, .rd_data, .rd_data_oe);

// file: tb/ram_block_tb.sv
/*
  bench for ram_block: bus master tasks, partner logic, one task per scenario.
  assumes the checker binds itself and the partner holds each write four cycles.
*/
`timescale 1ns/1ps
module ram_block_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, sync = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [4:0]  addr = 5'h0, rd_addr = 5'h0, wr_addr;
  logic [3:0]  data = 4'h0, din_in, din_out, rd_data;
  logic        hreadyout, hresp, wr_enable_n, din_oe, sector_clk, rd_data_oe;
  int          errors = 0, check_count = 0;
  // clock
  always #5 hclk = ~hclk;
  ram_block u_ram_block (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .sector_clk, .wr_addr, .wr_enable_n,
    .din_in, .din_out, .din_oe, .rd_addr, .rd_data, .rd_data_oe);
  array_user u_array_user (.hclk, .go, .sync, .addr, .data, .din_oe, .din_out, .wr_addr, .wr_enable_n,
    .din_in, .sector_clk);
  task automatic stop_test(input int extra);
    errors += extra;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // wait for hready with a bound
  task automatic waitrdy;
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
      if (++n > 50) stop_test(1);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    waitrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitrdy();
    rd = hrdata;
  endtask
  task automatic rdw(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pwr(input logic [4:0] a, input logic [3:0] d);
    @(posedge hclk);
    go <= 1'b1;
    addr <= a;
    data <= d;
    @(posedge hclk);
    go <= 1'b0;
    cyc(8);
  endtask
  task automatic peek(input logic [4:0] a, input logic [3:0] exp);
    rd_addr <= a;
    cyc(2);
    chk(32'(rd_data), 32'(exp));
  endtask
  // reset values, outputs off, unmapped offset
  task automatic t_reset;
    rdw(8'h00, 32'h7);
    rdw(8'h04, 32'h000f1003);
    rdw(8'h0c, 32'h0);
    chk(32'(rd_data_oe), 32'h0);
    $display("test reset done");
  endtask
  // every word written async, read by window and read port
  task automatic t_async;
    bus(1'b1, 8'h00, 32'h1);
    for (int i = 0; i < 32; i++)
      pwr(5'(i), 4'(i) ^ 4'h9);
    for (int i = 0; i < 32; i++) begin
      rdw(8'h80 + 8'(4 * i), 32'(4'(i) ^ 4'h9));
      peek(5'(i), 4'(i) ^ 4'h9);
    end
    chk(32'(rd_data_oe), 32'h1);
    $display("test async done");
  endtask
  // sync write lands; with the sector clock stopped nothing lands
  task automatic t_sync;
    bus(1'b1, 8'h00, 32'h3);
    sync <= 1'b1;
    pwr(5'h07, 4'h6);
    rdw(8'h9c, 32'h6);
    sync <= 1'b0;
    pwr(5'h08, 4'h5);
    rdw(8'ha0, 32'h1);
    $display("test sync done");
  endtask
  // single port: shared address, block drives the data pin
  task automatic t_single;
    bus(1'b1, 8'h00, 32'h0);
    pwr(5'h09, 4'hc);
    chk(32'(din_oe), 32'h1);
    chk(32'(din_out), 32'hc);
    $display("test single done");
  endtask
  // ce pause, then clear the whole array
  task automatic t_clear;
    bus(1'b1, 8'h00, 32'h1);
    ce <= 1'b0;
    cyc(3);
    ce <= 1'b1;
    bus(1'b1, 8'h08, 32'h5);
    rdw(8'h94, 32'h0);
    peek(5'h1f, 4'h0);
    $display("test clear done");
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_async();
    t_sync();
    t_single();
    t_clear();
    stop_test(0);
  end
endmodule
